// ---- design/ddb_regs.svh ----
// Register offsets, field positions and reset values for the digital data block.
// Included by the block and the bench; holds definitions only.
`ifndef DDB_REGS_SVH
`define DDB_REGS_SVH
`define DDB_ADDR_COUNT 3'h0
`define DDB_ADDR_PERIOD 3'h1
`define DDB_ADDR_CAPCMP 3'h2
`define DDB_ADDR_CTRL 3'h3
`define DDB_CTRL_ENABLE_BIT 0
`define DDB_CTRL_FULLTC_BIT 1
`define DDB_RESET_BYTE 8'h00
`define DDB_READ_ZERO 8'h00
`endif

// ---- design/ddb_pkg.sv ----
// Types shared by the digital data block and its bench.
// Assumes ddb_regs.svh is on the include path.
package ddb_pkg;
  typedef enum logic [1:0] {
    DDB_FN_TIMER,
    DDB_FN_COUNTER,
    DDB_FN_DEADBAND,
    DDB_FN_CRCSEQ
  } ddb_func_e;
  typedef enum logic [2:0] {
    DDB_CMP_LE,
    DDB_CMP_LT,
    DDB_CMP_EQ,
    DDB_CMP_GE,
    DDB_CMP_GT
  } ddb_cmp_e;
endpackage

// ---- design/ddb_block.sv ----
// Configurable 8-bit digital block: timer, counter, dead band, CRC/sequence.
// Assumes a one-cycle strobe bus master, synchronous inputs, single clock.
// What this block does
// - Count register holds down counter, hidden.
// - Disabled period write also loads count, except in sequence mode.
// - Disabled count read returns zero, captures.
// - Enabled timer count read captures, chain too.
// - Timer software capture blocked while capture input high.
// - Period plus one clocks, reload after end.
// - Timer period zero: inverted clock or high.
// - Enabled period write reloads after period end.
// - Timer capture event copies count to capture.
// - Timer compare drives auxiliary output.
// - Timer capture writes only while disabled.
// - Counter read captures when disabled or gated.
// - Counter period zero drives auxiliary high.
// - Counter compare drives primary output.
// - Counter capture register always writable.
// - Counter behaviour follows enable bit and gate: gate low holds count.
// - Dead band period zero gives one clock.
// - Sequence mode shift state, seed loads it.
// - Sequence compare drives auxiliary output.
// - Disabled sequence read captures residue.
// - Control bit zero enables synchronously.
`timescale 1ns/100ps
`include "ddb_regs.svh"
module ddb_block (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [2:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire ddb_pkg::ddb_func_e func_in,
  input wire ddb_pkg::ddb_cmp_e cmp_in,
  input wire logic data_in,
  input wire logic capture_in,
  input wire logic chain_capture_in,
  output logic chain_capture_out,
  output logic primary_out,
  output logic aux_out,
  output logic period_end_pulse_out
);
  import ddb_pkg::*;

  logic [7:0] count_state_reg;
  logic [7:0] period_reg;
  logic [7:0] capture_compare_reg;
  logic [7:0] ctrl_reg;
  logic enable;
  logic full_tc;
  logic terminal;
  logic cmp_hit;
  logic fb;
  logic capture_d_reg;
  logic [7:0] count_next;
  logic sw_capture;
  logic hw_capture;
  logic wr_period;
  logic wr_capcmp;
  logic wr_ctrl;
  logic rd_count;
  logic primary_next;
  logic aux_next;
  logic phase_reg;

  assign enable = ctrl_reg[`DDB_CTRL_ENABLE_BIT];
  assign full_tc = ctrl_reg[`DDB_CTRL_FULLTC_BIT];
  assign terminal = (count_state_reg == 8'h00);
  assign wr_period = wr_in && (addr_in == `DDB_ADDR_PERIOD);
  assign wr_capcmp = wr_in && (addr_in == `DDB_ADDR_CAPCMP);
  assign wr_ctrl = wr_in && (addr_in == `DDB_ADDR_CTRL);
  assign rd_count = rd_in && (addr_in == `DDB_ADDR_COUNT);

  // Compare type selected by configuration input
  always_comb begin
    case (cmp_in)
      DDB_CMP_LE: cmp_hit = (count_state_reg <= capture_compare_reg);
      DDB_CMP_LT: cmp_hit = (count_state_reg < capture_compare_reg);
      DDB_CMP_EQ: cmp_hit = (count_state_reg == capture_compare_reg);
      DDB_CMP_GE: cmp_hit = (count_state_reg >= capture_compare_reg);
      DDB_CMP_GT: cmp_hit = (count_state_reg > capture_compare_reg);
      default: cmp_hit = 1'b0;
    endcase
  end

  // Software capture from a count read, per function
  always_comb begin
    sw_capture = 1'b0;
    case (func_in)
      DDB_FN_TIMER: sw_capture = rd_count && !capture_in;
      DDB_FN_COUNTER: sw_capture = rd_count && (!enable || !data_in);
      DDB_FN_DEADBAND: sw_capture = rd_count && !enable;
      DDB_FN_CRCSEQ: sw_capture = rd_count && !enable;
      default: sw_capture = 1'b0;
    endcase
  end

  // Rising capture edge, or a lower block of the chain capturing
  assign hw_capture = (func_in == DDB_FN_TIMER) && enable &&
                      ((capture_in && !capture_d_reg) || chain_capture_in);

  // Sequence feedback: parity of tapped state bits
  assign fb = ^(count_state_reg & period_reg);

  always_comb begin
    count_next = count_state_reg;
    if (!enable) begin
      if (func_in == DDB_FN_CRCSEQ) begin
        if (wr_capcmp) begin
          count_next = wdata_in;
        end
      end else if (wr_period) begin
        count_next = wdata_in;
      end
    end else if (func_in == DDB_FN_CRCSEQ) begin
      count_next = {count_state_reg[6:0], fb};
    end else if (func_in == DDB_FN_COUNTER && !data_in) begin
      count_next = count_state_reg;
    end else if (terminal) begin
      count_next = period_reg;
    end else begin
      count_next = count_state_reg - 8'h01;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      count_state_reg <= `DDB_RESET_BYTE;
    end else begin
      count_state_reg <= count_next;
    end
  end

  // Period writes accepted at any time; polynomial timing is software's job
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      period_reg <= `DDB_RESET_BYTE;
    end else if (wr_period) begin
      period_reg <= wdata_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      ctrl_reg <= `DDB_RESET_BYTE;
    end else if (wr_ctrl) begin
      ctrl_reg <= wdata_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      capture_d_reg <= 1'b0;
    end else begin
      capture_d_reg <= capture_in;
    end
  end

  // Capture wins over a bus write in the same cycle
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      capture_compare_reg <= `DDB_RESET_BYTE;
    end else if (sw_capture || hw_capture) begin
      capture_compare_reg <= count_state_reg;
    end else if (wr_capcmp) begin
      if (func_in != DDB_FN_TIMER || !enable) begin
        capture_compare_reg <= wdata_in;
      end
    end
  end

  // Higher bytes of a chained timer capture one clock after this one
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      chain_capture_out <= 1'b0;
    end else begin
      chain_capture_out <= (func_in == DDB_FN_TIMER) && enable &&
                           (rd_count && !capture_in);
    end
  end

  // Count reads always return zero; hidden state never reaches the bus
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      rdata_out <= `DDB_READ_ZERO;
    end else if (rd_in) begin
      case (addr_in)
        `DDB_ADDR_COUNT: rdata_out <= `DDB_READ_ZERO;
        `DDB_ADDR_CAPCMP: rdata_out <= capture_compare_reg;
        `DDB_ADDR_CTRL: rdata_out <= ctrl_reg;
        default: rdata_out <= `DDB_READ_ZERO;
      endcase
    end else begin
      rdata_out <= `DDB_READ_ZERO;
    end
  end

  // Half-cycle terminal output modelled as a one-clock phase toggle
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      phase_reg <= 1'b0;
    end else begin
      phase_reg <= !phase_reg;
    end
  end

  always_comb begin
    primary_next = 1'b0;
    aux_next = 1'b0;
    case (func_in)
      DDB_FN_TIMER: begin
        if (enable && period_reg == 8'h00) begin
          primary_next = full_tc ? 1'b1 : phase_reg;
        end else begin
          primary_next = enable && terminal;
        end
        aux_next = enable && cmp_hit;
      end
      DDB_FN_COUNTER: begin
        primary_next = enable && cmp_hit;
        aux_next = (period_reg == 8'h00) ? 1'b1 : (enable && terminal);
      end
      DDB_FN_DEADBAND: begin
        primary_next = enable && !terminal;
        aux_next = enable && terminal;
      end
      DDB_FN_CRCSEQ: begin
        primary_next = count_state_reg[7];
        aux_next = enable && cmp_hit;
      end
      default: begin
        primary_next = 1'b0;
        aux_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      primary_out <= 1'b0;
      aux_out <= 1'b0;
      period_end_pulse_out <= 1'b0;
    end else begin
      primary_out <= primary_next;
      aux_out <= aux_next;
      period_end_pulse_out <= enable && terminal && func_in != DDB_FN_CRCSEQ;
    end
  end

  sequence s_count_read;
    rd_in && addr_in == `DDB_ADDR_COUNT;
  endsequence

  a_count_reads_zero: assert property (@(posedge clk_in) disable iff (!resetn_in)
    s_count_read |=> rdata_out == 8'h00) else $error("count read not zero");
  a_disabled_period_load: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (wr_period && !enable && func_in != DDB_FN_CRCSEQ) |=> count_state_reg == $past(wdata_in))
    else $error("period not loaded into count");
  a_capture_on_read: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (s_count_read and (!enable && func_in != DDB_FN_COUNTER &&
                       !(func_in == DDB_FN_TIMER && capture_in)))
    |=> capture_compare_reg == $past(count_state_reg)) else $error("read did not capture");
  a_sw_capture_masked: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (s_count_read and (func_in == DDB_FN_TIMER && capture_in && !enable && !wr_capcmp))
    |=> $stable(capture_compare_reg)) else $error("masked capture happened");
  a_reload_after_end: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (enable && terminal && func_in == DDB_FN_TIMER && $stable(enable))
    |=> count_state_reg == $past(period_reg)) else $error("no reload at period end");
  a_down_count: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (enable && !terminal && func_in == DDB_FN_TIMER && $stable(enable))
    |=> count_state_reg == $past(count_state_reg) - 8'h01) else $error("count did not decrement");
  a_timer_write_block: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (wr_capcmp && enable && func_in == DDB_FN_TIMER && !hw_capture && !sw_capture)
    |=> $stable(capture_compare_reg)) else $error("enabled timer accepted write");
  a_counter_zero_aux: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (func_in == DDB_FN_COUNTER && period_reg == 8'h00) |=> aux_out)
    else $error("counter zero period aux low");
  a_seed_load: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (wr_capcmp && !enable && func_in == DDB_FN_CRCSEQ) |=> count_state_reg == $past(wdata_in))
    else $error("seed not loaded");
  a_counter_compare: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (func_in == DDB_FN_COUNTER && enable) |=> primary_out == $past(cmp_hit))
    else $error("counter primary not compare");

  // Per-function views of an enabled block, shared by the checks below
  sequence s_timer_on;
    func_in == DDB_FN_TIMER && enable;
  endsequence

  sequence s_counter_on;
    func_in == DDB_FN_COUNTER && enable;
  endsequence

  sequence s_seq_on;
    func_in == DDB_FN_CRCSEQ && enable;
  endsequence

  sequence s_half_zero;
    func_in == DDB_FN_TIMER && enable && period_reg == 8'h00 && !full_tc;
  endsequence

  // Two half-mode cycles in a row must show opposite levels
  a_half_toggle: assert property (@(posedge clk_in) disable iff (!resetn_in)
    s_half_zero ##1 s_half_zero |=> primary_out != $past(primary_out))
    else $error("half mode primary not toggling");

  a_full_high: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (s_timer_on and (period_reg == 8'h00 && full_tc)) |=> primary_out)
    else $error("full mode primary not high");

  // Compare checks spell the compare out rather than reuse the design's hit
  a_timer_aux_eq: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (s_timer_on and (cmp_in == DDB_CMP_EQ && count_state_reg == capture_compare_reg))
    |=> aux_out) else $error("timer equal compare not on aux");

  a_timer_aux_miss: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (s_timer_on and (cmp_in == DDB_CMP_EQ && count_state_reg != capture_compare_reg))
    |=> !aux_out) else $error("timer unequal compare on aux");

  a_hw_capture: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (s_timer_on and $rose(capture_in)) |=> capture_compare_reg == $past(count_state_reg))
    else $error("capture edge did not copy count");

  a_timer_read_capture: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (s_count_read and s_timer_on and !capture_in)
    |=> capture_compare_reg == $past(count_state_reg) && chain_capture_out)
    else $error("enabled read did not capture");

  a_chain_capture_in: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (s_timer_on and chain_capture_in) |=> capture_compare_reg == $past(count_state_reg))
    else $error("chained capture did not copy count");

  a_enabled_period_defer: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (s_timer_on and (wr_period && !terminal)) |=> count_state_reg == $past(count_state_reg) - 8'h01)
    else $error("enabled period write reached count early");

  a_period_store: assert property (@(posedge clk_in) disable iff (!resetn_in)
    wr_period |=> period_reg == $past(wdata_in))
    else $error("period write not stored");

  a_counter_write_ok: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (wr_capcmp && func_in == DDB_FN_COUNTER && !sw_capture) |=> capture_compare_reg == $past(wdata_in))
    else $error("counter compare write lost");

  a_counter_lt_primary: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (s_counter_on and (cmp_in == DDB_CMP_LT && count_state_reg < capture_compare_reg))
    |=> primary_out) else $error("counter less-than not on primary");

  a_gate_holds_count: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (s_counter_on and !data_in) |=> $stable(count_state_reg))
    else $error("gated counter moved");

  a_gate_low_capture: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (s_count_read and (func_in == DDB_FN_COUNTER && !data_in))
    |=> capture_compare_reg == $past(count_state_reg)) else $error("gated read did not capture");

  a_dead_zero_period: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (func_in == DDB_FN_DEADBAND && enable && period_reg == 8'h00 && terminal)
    |=> period_end_pulse_out && count_state_reg == 8'h00) else $error("dead band zero not one clock");

  a_seq_shift: assert property (@(posedge clk_in) disable iff (!resetn_in)
    s_seq_on |=> count_state_reg[7:1] == $past(count_state_reg[6:0]))
    else $error("sequence state did not shift");

  a_seq_write_ok: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (s_seq_on and wr_capcmp) |=> capture_compare_reg == $past(wdata_in))
    else $error("enabled sequence compare write lost");

  a_seq_aux_gt: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (s_seq_on and (cmp_in == DDB_CMP_GT && count_state_reg > capture_compare_reg))
    |=> aux_out) else $error("sequence compare not on aux");

  a_residue_capture: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (s_count_read and (func_in == DDB_FN_CRCSEQ && !enable))
    |=> capture_compare_reg == $past(count_state_reg)) else $error("residue not captured");

  a_disabled_hold: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (!enable && !wr_period && !wr_capcmp) |=> $stable(count_state_reg))
    else $error("disabled count moved");

  a_rdata_zero_else: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (!rd_in || addr_in == `DDB_ADDR_PERIOD) |=> rdata_out == 8'h00)
    else $error("read data not zero");
endmodule

// ---- bench/tb_ddb_block.sv ----
// Self-checking bench for the digital data block: bus access, timer, counter, sequence.
// Assumes the design files and ddb_regs.svh are compiled first, one 40 MHz clock.
`timescale 1ns/100ps
`include "ddb_regs.svh"
module tb_ddb_block;
  import ddb_pkg::*;
  logic clk_in, resetn_in, wr_in, rd_in, data_in, capture_in, prev, chain_in;
  logic [2:0] addr_in;
  logic [7:0] wdata_in, rdata_out, v, crc, poly;
  ddb_func_e func_in;
  ddb_cmp_e cmp_in;
  logic chain_capture_out, primary_out, aux_out, period_end_pulse_out;
  logic rd_pend = 1'b0;
  logic [7:0] exp_q[$];
  int miscompares, cmp_count, seed, n;

  ddb_block u_ddb_block (.clk_in(clk_in), .resetn_in(resetn_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .func_in(func_in), .cmp_in(cmp_in), .data_in(data_in), .capture_in(capture_in),
    .chain_capture_in(chain_in), .chain_capture_out(chain_capture_out),
    .primary_out(primary_out), .aux_out(aux_out),
    .period_end_pulse_out(period_end_pulse_out));

  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask

  // Expected value queued first; the monitor pops it when the data appear
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    exp_q.push_back(exp);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
  endtask

  // Cycles between two terminal pulses; bounded so a dead counter cannot hang
  task automatic gap(output int g);
    g = 0;
    while (period_end_pulse_out !== 1'b1 && g < 50) begin
      @(posedge clk_in);
      g++;
    end
    g = 0;
    do begin
      @(posedge clk_in);
      g++;
    end while (period_end_pulse_out !== 1'b1 && g < 50);
  endtask

  function automatic logic cmpf(input int c, input logic [7:0] a, input logic [7:0] b);
    case (c)
      0: return a <= b;
      1: return a < b;
      2: return a == b;
      3: return a >= b;
      default: return a > b;
    endcase
  endfunction

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge clk_in) begin
    if (rd_pend === 1'b1 && exp_q.size() > 0) begin
      chk("rdata_out", exp_q.pop_front(), rdata_out);
    end
    rd_pend <= rd_in;
  end

  initial begin
    repeat (5000) @(posedge clk_in);
    miscompares++;
    final_report();
  end

  initial begin
    seed = 88;
    {wr_in, rd_in, data_in, capture_in, chain_in, addr_in, wdata_in} = '0;
    func_in = DDB_FN_TIMER;
    cmp_in = DDB_CMP_EQ;
    resetn_in = 1'b0;
    repeat (4) @(posedge clk_in);
    resetn_in <= 1'b1;
    wr(`DDB_ADDR_PERIOD, 8'h05);
    rd(`DDB_ADDR_COUNT, `DDB_READ_ZERO);
    rd(`DDB_ADDR_CAPCMP, 8'h05);
    rd(`DDB_ADDR_PERIOD, 8'h00);
    wr(3'h6, 8'hff);
    rd(3'h5, 8'h00);
    rd(`DDB_ADDR_CAPCMP, 8'h05);
    v = 8'($random(seed)) | 8'h01;
    capture_in <= 1'b1;
    wr(`DDB_ADDR_CAPCMP, v);
    rd(`DDB_ADDR_COUNT, `DDB_READ_ZERO);
    rd(`DDB_ADDR_CAPCMP, v);
    capture_in <= 1'b0;
    $display("test disabled_access done");
    wr(`DDB_ADDR_PERIOD, 8'h03);
    wr(`DDB_ADDR_CTRL, 8'h01);
    rd(`DDB_ADDR_CTRL, 8'h01);
    rd(`DDB_ADDR_COUNT, `DDB_READ_ZERO);
    @(posedge clk_in);
    chk("chain_capture_out", 8'h01, {7'h0, chain_capture_out});
    wr(`DDB_ADDR_CTRL, 8'h00);
    wr(`DDB_ADDR_CAPCMP, v);
    wr(`DDB_ADDR_CTRL, 8'h01);
    wr(`DDB_ADDR_CAPCMP, ~v);
    gap(n);
    chk("period clocks", 8'd4, n[7:0]);
    wr(`DDB_ADDR_PERIOD, 8'h06);
    @(posedge clk_in);
    gap(n);
    chk("reloaded period clocks", 8'd7, n[7:0]);
    wr(`DDB_ADDR_CTRL, 8'h00);
    rd(`DDB_ADDR_CAPCMP, v);
    $display("test timer_period done");
    wr(`DDB_ADDR_PERIOD, 8'h00);
    wr(`DDB_ADDR_CTRL, 8'h01);
    repeat (3) @(posedge clk_in);
    prev = primary_out;
    @(posedge clk_in);
    chk("half mode primary", {7'h0, ~prev}, {7'h0, primary_out});
    wr(`DDB_ADDR_CTRL, 8'h03);
    repeat (3) @(posedge clk_in);
    chk("full mode primary", 8'h01, {7'h0, primary_out});
    chk("timer aux miss", 8'h00, {7'h0, aux_out});
    capture_in <= 1'b1;
    @(posedge clk_in);
    capture_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    chk("timer aux hit", 8'h01, {7'h0, aux_out});
    wr(`DDB_ADDR_CTRL, 8'h00);
    wr(`DDB_ADDR_CAPCMP, v);
    wr(`DDB_ADDR_CTRL, 8'h01);
    chain_in <= 1'b1;
    @(posedge clk_in);
    chain_in <= 1'b0;
    wr(`DDB_ADDR_CTRL, 8'h00);
    rd(`DDB_ADDR_CAPCMP, 8'h00);
    $display("test timer_zero done");
    func_in <= DDB_FN_COUNTER;
    data_in <= 1'b1;
    wr(`DDB_ADDR_CTRL, 8'h01);
    // Period zero keeps the count at zero, so each compare code has a fixed answer
    for (int c = 0; c < 5; c++) begin
      for (int b = 0; b < 2; b++) begin
        wr(`DDB_ADDR_CAPCMP, b[7:0]);
        cmp_in <= ddb_cmp_e'(c);
        repeat (3) @(posedge clk_in);
        chk("counter primary", {7'h0, cmpf(c, 8'h00, b[7:0])}, {7'h0, primary_out});
      end
    end
    chk("counter aux", 8'h01, {7'h0, aux_out});
    rd(`DDB_ADDR_CAPCMP, 8'h01);
    data_in <= 1'b0;
    rd(`DDB_ADDR_COUNT, `DDB_READ_ZERO);
    rd(`DDB_ADDR_CAPCMP, 8'h00);
    wr(`DDB_ADDR_CTRL, 8'h00);
    $display("test counter done");
    func_in <= DDB_FN_DEADBAND;
    wr(`DDB_ADDR_CTRL, 8'h01);
    gap(n);
    chk("dead band clocks", 8'd1, n[7:0]);
    chk("dead band aux", 8'h01, {7'h0, aux_out});
    wr(`DDB_ADDR_CTRL, 8'h00);
    $display("test dead_band done");
    func_in <= DDB_FN_CRCSEQ;
    poly = 8'($random(seed));
    crc = 8'($random(seed)) | 8'h01;
    wr(`DDB_ADDR_PERIOD, poly);
    wr(`DDB_ADDR_CAPCMP, crc);
    wr(`DDB_ADDR_CTRL, 8'h01);
    wr(`DDB_ADDR_CAPCMP, 8'h00);
    rd(`DDB_ADDR_CAPCMP, 8'h00);
    @(posedge clk_in);
    wr(`DDB_ADDR_CTRL, 8'h00);
    // Enabled from the edge after the set to the edge of the clear: seven shifts
    for (n = 0; n < 7; n++) begin
      crc = {crc[6:0], ^(crc & poly)};
    end
    rd(`DDB_ADDR_COUNT, `DDB_READ_ZERO);
    rd(`DDB_ADDR_CAPCMP, crc);
    repeat (3) @(posedge clk_in);
    $display("test sequence done");
    final_report();
  end
endmodule
